/* cxd_ext_display.sv */
// Extended display controls of the CRT timing unit, running on the pixel clock.
// Assumes one clock, registers reached through an index port and a data port, and
// the base timing unit supplying blanking, sync and total match beside it.
`timescale 1ns/100ps
`include "cxd_defines.svh"

module cxd_ext_display
(
   input  wire logic        MCLK,
   input  wire logic        SYS_RST,
   input  wire logic        IO_WR,
   input  wire logic        IO_RD,
   input  wire logic        IO_DATA_SEL,
   input  wire logic [7:0]  IO_WDATA,
   output logic      [7:0]  IO_RDATA,
   input  wire logic [7:0]  BLANK_OVERFLOW_MISC,
   input  wire logic [7:0]  ROW_OFFSET_LO,
   input  wire logic        DWORD_MODE,
   input  wire logic        CHAIN4_MODE,
   input  wire logic [15:0] START_ADDR_LO,
   input  wire logic [16:0] HOST_ADDR,
   input  wire logic [6:0]  HOST_OFFSET,
   input  wire logic        CRTC_BLANK,
   input  wire logic        DISPLAY_EN,
   input  wire logic        OVERLAY_WIN_INT,
   input  wire logic        HSYNC_INT,
   input  wire logic        VSYNC_INT,
   input  wire logic        HTOTAL_MATCH,
   input  wire logic        FIELD_END,
   input  wire logic        FRAME_START,
   input  wire logic        HSYNC_I,
   input  wire logic        VSYNC_I,
   input  wire logic        EXT_VIDEO_WINDOW_IN_N,
   input  wire logic [15:0] GFX_PIXEL,
   input  wire logic [7:0]  COLOR_KEY_LOW,
   input  wire logic [7:0]  COLOR_KEY_HIGH,
   input  wire logic        CHROMA_IN_RANGE,
   output logic             BLANK_END_EXT_EN,
   output logic [1:0]       VBLANK_END_HI,
   output logic [1:0]       HBLANK_END_HI,
   output logic             FONT_FAST_PAGE,
   output logic             DAC_BLANK,
   output logic             OVERLAY_WINDOW_OUT_N,
   output logic [8:0]       ROW_OFFSET,
   output logic [19:0]      START_ADDR,
   output logic [18:0]      CRTC_MEM_ADDR,
   output logic [18:0]      DRAM_HOST_ADDR,
   output logic             HSYNC_O,
   output logic             HSYNC_OE,
   output logic             VSYNC_O,
   output logic             VSYNC_OE,
   output logic             HSYNC_RESTART,
   output logic             VSYNC_RESTART,
   output logic             FIELD_ODD,
   output logic             CHAR_CLK,
   output logic             OVERLAY_TIMING,
   output logic             COLOR_KEY_MATCH,
   output logic             OVERLAY_SWITCH,
   output logic             DAC_SWITCH,
   output logic             PIXEL_PORT_OE
);

   // ***************************************************************************
   // Register file behind the index and data ports.
   // ***************************************************************************

   logic [7:0]               index_q, index_d;       // Selected register index.
   cxd_pkg::cxd_ext_disp_type edc_q, edc_d;          // Extended display control.
   cxd_pkg::cxd_sync_adj_type sync_q, sync_d;        // Sync adjust and lock.
   cxd_pkg::cxd_ovl_ext_type  ovl_q, ovl_d;          // Overlay extended control.
   logic [7:0]               rdata_q, rdata_d;       // Read data returned on the port.

   // Computes register writes and the read data of the addressed register.
   always_comb
   begin
      index_d = index_q;
      edc_d   = edc_q;
      sync_d  = sync_q;
      ovl_d   = ovl_q;
      rdata_d = rdata_q;
      if (IO_WR && !IO_DATA_SEL)
      begin
         index_d = IO_WDATA;
      end
      else if (IO_WR)
      begin
         // Writes to read-only or unmapped indices are dropped.
         case (index_q)
            `CXD_IDX_EXT_DISP : edc_d  = IO_WDATA;
            `CXD_IDX_SYNC_ADJ : sync_d = IO_WDATA;
            `CXD_IDX_OVL_EXT  : ovl_d  = IO_WDATA & `CXD_OVL_WRITE_MASK;
            default           : ;
         endcase
      end
      if (IO_RD && !IO_DATA_SEL)
      begin
         rdata_d = index_q;
      end
      else if (IO_RD)
      begin
         // Unmapped indices read as zero.
         case (index_q)
            `CXD_IDX_EXT_DISP  : rdata_d = edc_q;
            `CXD_IDX_SYNC_ADJ  : rdata_d = sync_q;
            `CXD_IDX_OVL_EXT   : rdata_d = ovl_q & `CXD_OVL_WRITE_MASK;
            `CXD_IDX_PART_STAT : rdata_d = `CXD_PART_STATUS;
            `CXD_IDX_DEV_IDENT : rdata_d = {`CXD_DEVICE_ID, 2'h0};
            default            : rdata_d = 8'h00;
         endcase
      end
   end

   // Registers the register file.
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         index_q <= `CXD_RST_INDEX;
         edc_q   <= `CXD_RST_EXT_DISP;
         sync_q  <= `CXD_RST_SYNC_ADJ;
         ovl_q   <= `CXD_RST_OVL_EXT;
         rdata_q <= 8'h00;
      end
      else
      begin
         index_q <= index_d;
         edc_q   <= edc_d;
         sync_q  <= sync_d;
         ovl_q   <= ovl_d;
         rdata_q <= rdata_d;
      end
   end

   assign IO_RDATA = rdata_q;

   // ***************************************************************************
   // Pin synchronisers: three stages, a change counts once stages two and three agree.
   // ***************************************************************************

   logic [2:0] pin_raw;                     // Vertical sync, horizontal sync, window pins.
   logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q; // Synchroniser stages.
   logic [2:0] pin_filt_q, pin_filt_d;      // Accepted pin levels.
   localparam logic [2:0] PIN_IDLE = `CXD_RST_PINS; // Idle levels, so no false window follows reset.

   assign pin_raw = {EXT_VIDEO_WINDOW_IN_N, HSYNC_I, VSYNC_I};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_pin
         // Accepts a new level only when the last two stages agree.
         always_comb
         begin
            pin_filt_d[gi] = (pin_s2_q[gi] == pin_s3_q[gi]) ? pin_s3_q[gi] : pin_filt_q[gi];
         end

         // Registers the stages and the accepted level.
         always_ff @(posedge MCLK)
         begin
            if (SYS_RST)
            begin
               pin_s1_q[gi]   <= PIN_IDLE[gi];
               pin_s2_q[gi]   <= PIN_IDLE[gi];
               pin_s3_q[gi]   <= PIN_IDLE[gi];
               pin_filt_q[gi] <= PIN_IDLE[gi];
            end
            else
            begin
               pin_s1_q[gi]   <= pin_raw[gi];
               pin_s2_q[gi]   <= pin_s1_q[gi];
               pin_s3_q[gi]   <= pin_s2_q[gi];
               pin_filt_q[gi] <= pin_filt_d[gi];
            end
         end
      end
   endgenerate

   // ***************************************************************************
   // Character clock with horizontal total adjust and the character address counter.
   // ***************************************************************************

   cxd_pkg::cxd_adj_state_type adj_q, adj_d; // Adjust sequencer state.
   logic [1:0]  lag_q, lag_d;                // Character ends left before the adjusted one.
   logic [3:0]  pix_q, pix_d;                // Pixel within the character.
   logic [18:0] ca_q, ca_d;                  // Character address counter.
   logic [3:0]  char_len;                    // Length of the current character.
   logic [3:0]  adj_len;                     // Adjusted length from the code.
   logic        char_end;                    // Last pixel of the current character.

   // Works out the adjusted length: 001..011 shorten by 3..1, 100..111 lengthen by 1..4.
   always_comb
   begin
      if (sync_q.htotal_adj == 3'h0)
      begin
         adj_len = `CXD_CHAR_PIXELS;
      end
      else if (sync_q.htotal_adj[2])
      begin
         adj_len = `CXD_CHAR_PIXELS + {2'h0, sync_q.htotal_adj[1:0]} + 4'h1;
      end
      else
      begin
         adj_len = `CXD_CHAR_PIXELS - 4'h4 + {2'h0, sync_q.htotal_adj[1:0]};
      end
      char_len = (adj_q == cxd_pkg::ADJ_STRETCH) ? adj_len : `CXD_CHAR_PIXELS;
      char_end = (pix_q == char_len - 4'h1);
   end

   // Steps the pixel count, the adjust sequencer and the address counter.
   always_comb
   begin
      pix_d = char_end ? 4'h0 : pix_q + 4'h1;
      adj_d = adj_q;
      lag_d = lag_q;
      ca_d  = ca_q;
      case (adj_q)
         cxd_pkg::ADJ_IDLE :
         begin
            if (HTOTAL_MATCH)
            begin
               adj_d = cxd_pkg::ADJ_WAIT;
               lag_d = `CXD_HTOTAL_LAG;
            end
         end
         cxd_pkg::ADJ_WAIT :
         begin
            // The character that starts after the second character end is adjusted.
            if (char_end && lag_q == 2'h1)
            begin
               adj_d = cxd_pkg::ADJ_STRETCH;
            end
            else if (char_end)
            begin
               lag_d = lag_q - 2'h1;
            end
         end
         cxd_pkg::ADJ_STRETCH :
         begin
            if (char_end)
            begin
               adj_d = cxd_pkg::ADJ_IDLE;
            end
         end
         default :
         begin
            adj_d = cxd_pkg::ADJ_IDLE;
         end
      endcase
      if (FRAME_START)
      begin
         ca_d = START_ADDR[18:0];
      end
      else if (char_end && DISPLAY_EN && edc_q.ext_wrap)
      begin
         ca_d = ca_q + 19'h1;
      end
      else if (char_end && DISPLAY_EN)
      begin
         ca_d = {3'h0, ca_q[15:0] + 16'h1};
      end
   end

   // Registers the character timing state.
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         adj_q <= cxd_pkg::ADJ_IDLE;
         lag_q <= 2'h0;
         pix_q <= 4'h0;
         ca_q  <= 19'h0;
      end
      else
      begin
         adj_q <= adj_d;
         lag_q <= lag_d;
         pix_q <= pix_d;
         ca_q  <= ca_d;
      end
   end

   // ***************************************************************************
   // Sync delay, sync lock and interlace field state.
   // ***************************************************************************

   logic [6:0] hs_pipe_q, hs_pipe_d;   // Past internal horizontal sync levels.
   logic [7:0] hs_taps;                // Current and delayed sync levels.
   logic       vs_prev_q, vs_prev_d;   // Accepted vertical pin level, one cycle old.
   logic       hs_prev_q, hs_prev_d;   // Accepted horizontal pin level, one cycle old.
   logic       lock_prev_q, lock_prev_d; // Vertical lock bit, one cycle old.
   logic       arm_q, arm_d;           // Waiting for the first locked transition.
   logic       field_q, field_d;       // High during the odd field.

   // Tracks the pin history, arms on a lock enable and steps the field.
   always_comb
   begin
      hs_pipe_d   = {hs_pipe_q[5:0], HSYNC_INT};
      hs_taps     = {hs_pipe_q, HSYNC_INT};
      vs_prev_d   = pin_filt_q[0];
      hs_prev_d   = pin_filt_q[1];
      lock_prev_d = sync_q.vsync_lock;
      arm_d       = arm_q;
      field_d     = field_q;
      if (sync_q.vsync_lock && !lock_prev_q)
      begin
         arm_d = 1'b1;
      end
      if (!sync_q.vsync_lock)
      begin
         arm_d = 1'b0;
      end
      if (arm_q && sync_q.vsync_lock && BLANK_OVERFLOW_MISC[`CXD_MISC_INTERLACE]
          && (pin_filt_q[0] != vs_prev_q))
      begin
         field_d = 1'b0;
         arm_d   = 1'b0;
      end
      else if (FIELD_END && BLANK_OVERFLOW_MISC[`CXD_MISC_INTERLACE])
      begin
         field_d = !field_q;
      end
   end

   // Registers the sync state.
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         hs_pipe_q   <= 7'h0;
         vs_prev_q   <= 1'b0;
         hs_prev_q   <= 1'b0;
         lock_prev_q <= 1'b0;
         arm_q       <= 1'b0;
         field_q     <= 1'b0;
      end
      else
      begin
         hs_pipe_q   <= hs_pipe_d;
         vs_prev_q   <= vs_prev_d;
         hs_prev_q   <= hs_prev_d;
         lock_prev_q <= lock_prev_d;
         arm_q       <= arm_d;
         field_q     <= field_d;
      end
   end

   // ***************************************************************************
   // Output stage: every output except IO_RDATA is registered here.
   // ***************************************************************************

   logic         blank_ext;  // Blank end extension bits honoured.
   logic         overlay_window_out_act;   // Internal overlay window, active high.
   logic         timing_src; // Selected overlay timing.
   logic         key_hit;    // Colour or chroma key match.
   logic         sw_on;      // Overlay switch term.
   logic [18:0]  extended_mem_addr;        // Extended host memory address.
   cxd_pkg::cxd_switch_type sw_mode; // Decoded switch selection.

   // Forms the combinational values that the output flops take.
   always_comb
   begin
      blank_ext  = edc_q.blank_ext_en | edc_q.blank_from_de;
      overlay_window_out_act   = edc_q.blank_from_de ? CRTC_BLANK : OVERLAY_WIN_INT;
      timing_src = ovl_q.timing_internal ? overlay_window_out_act : !pin_filt_q[2];
      if (ovl_q.chroma_select)
      begin
         key_hit = CHROMA_IN_RANGE;
      end
      else if (ovl_q.key_width16 && ovl_q.key_tag_en)
      begin
         key_hit = (GFX_PIXEL[15] == COLOR_KEY_HIGH[7]);
      end
      else if (ovl_q.key_width16)
      begin
         key_hit = (GFX_PIXEL == {COLOR_KEY_HIGH, COLOR_KEY_LOW});
      end
      else
      begin
         key_hit = (GFX_PIXEL[7:0] == COLOR_KEY_LOW);
      end
      sw_mode = cxd_pkg::cxd_switch_type'(BLANK_OVERFLOW_MISC[`CXD_MISC_SW_LO +: 2]);
      case (sw_mode)
         cxd_pkg::SW_OFF        : sw_on = 1'b0;
         cxd_pkg::SW_TIMING     : sw_on = timing_src;
         cxd_pkg::SW_TIMING_KEY : sw_on = timing_src & key_hit;
         cxd_pkg::SW_KEY_ONLY   : sw_on = key_hit;
         default                : sw_on = 1'b0;
      endcase
      extended_mem_addr = {HOST_ADDR[16:12] + HOST_OFFSET, HOST_ADDR[11:0]};
   end

   // Registers the outputs.
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         BLANK_END_EXT_EN     <= 1'b0;
         VBLANK_END_HI        <= 2'h0;
         HBLANK_END_HI        <= 2'h0;
         FONT_FAST_PAGE       <= 1'b0;
         DAC_BLANK            <= 1'b0;
         OVERLAY_WINDOW_OUT_N <= 1'b1;
         ROW_OFFSET           <= 9'h0;
         START_ADDR           <= 20'h0;
         CRTC_MEM_ADDR        <= 19'h0;
         DRAM_HOST_ADDR       <= 19'h0;
         HSYNC_O              <= 1'b0;
         HSYNC_OE             <= 1'b0;
         VSYNC_O              <= 1'b0;
         VSYNC_OE             <= 1'b0;
         HSYNC_RESTART        <= 1'b0;
         VSYNC_RESTART        <= 1'b0;
         FIELD_ODD            <= 1'b0;
         CHAR_CLK             <= 1'b0;
         OVERLAY_TIMING       <= 1'b0;
         COLOR_KEY_MATCH      <= 1'b0;
         OVERLAY_SWITCH       <= 1'b0;
         DAC_SWITCH           <= 1'b0;
         PIXEL_PORT_OE        <= 1'b1;
      end
      else
      begin
         BLANK_END_EXT_EN     <= blank_ext;
         VBLANK_END_HI        <= blank_ext ? BLANK_OVERFLOW_MISC[`CXD_MISC_VBE_LO +: 2] : 2'h0;
         HBLANK_END_HI        <= blank_ext ? BLANK_OVERFLOW_MISC[`CXD_MISC_HBE_LO +: 2] : 2'h0;
         FONT_FAST_PAGE       <= edc_q.text_fast_page;
         DAC_BLANK            <= edc_q.blank_from_de ? !DISPLAY_EN : CRTC_BLANK;
         OVERLAY_WINDOW_OUT_N <= !overlay_window_out_act;
         ROW_OFFSET           <= {edc_q.row_offset_b8, ROW_OFFSET_LO};
         START_ADDR           <= {ovl_q.start_b19, edc_q.start_b18_17, edc_q.start_b16, START_ADDR_LO};
         if (edc_q.ext_wrap && DWORD_MODE)
         begin
            CRTC_MEM_ADDR <= {ca_q[18:2], ca_q[15], ca_q[14]};
         end
         else
         begin
            CRTC_MEM_ADDR <= ca_q;
         end
         if (edc_q.ext_wrap && CHAIN4_MODE)
         begin
            DRAM_HOST_ADDR <= {extended_mem_addr[18:2], extended_mem_addr[17], extended_mem_addr[16]};
         end
         else
         begin
            DRAM_HOST_ADDR <= {3'h0, HOST_ADDR[15:0]};
         end
         HSYNC_O              <= hs_taps[sync_q.hsync_delay];
         HSYNC_OE             <= !sync_q.hsync_lock;
         VSYNC_O              <= VSYNC_INT;
         VSYNC_OE             <= !sync_q.vsync_lock;
         HSYNC_RESTART        <= sync_q.hsync_lock && pin_filt_q[1] && !hs_prev_q;
         VSYNC_RESTART        <= sync_q.vsync_lock && pin_filt_q[0] && !vs_prev_q;
         FIELD_ODD            <= field_q;
         CHAR_CLK             <= char_end;
         OVERLAY_TIMING       <= timing_src;
         COLOR_KEY_MATCH      <= key_hit;
         OVERLAY_SWITCH       <= sw_on;
         DAC_SWITCH           <= ovl_q.dac_switch[1] ? 1'b0 : (sw_on ^ ovl_q.dac_switch[0]);
         PIXEL_PORT_OE        <= (sw_mode == cxd_pkg::SW_OFF);
      end
   end

endmodule : cxd_ext_display

/* cxd_defines.svh */
// Constants of the extended display controls: register indices, reset values, timing counts.
// Assumes it is included by the design file and the testbench through its bare name.
`ifndef CXD_DEFINES_SVH
`define CXD_DEFINES_SVH

// Register indices behind the indexed data port.
`define CXD_IDX_EXT_DISP     8'h1B
`define CXD_IDX_SYNC_ADJ     8'h1C
`define CXD_IDX_OVL_EXT      8'h1D
`define CXD_IDX_PART_STAT    8'h25
`define CXD_IDX_DEV_IDENT    8'h27

// Reset values of the writable registers.
`define CXD_RST_EXT_DISP     8'h00
`define CXD_RST_SYNC_ADJ     8'h00
`define CXD_RST_OVL_EXT      8'h00
`define CXD_RST_INDEX        8'h00
// Idle levels of the synchronised pins: window (active low), horizontal sync, vertical sync.
`define CXD_RST_PINS         3'h4

// Writable bits of the overlay control register; bit 0 is reserved.
`define CXD_OVL_WRITE_MASK   8'hFE

// Part status value; the value is arbitrary apart from bits 7 and 6.
`define CXD_PART_STATUS      8'h40
// Device identifier; the value is arbitrary.
`define CXD_DEVICE_ID        6'h15

// Positions of the loose bits taken from neighbouring registers.
`define CXD_MISC_INTERLACE   0
`define CXD_MISC_SW_LO       2
`define CXD_MISC_HBE_LO      4
`define CXD_MISC_VBE_LO      6

// Pixel clocks per character and character clocks from total match to the adjusted character.
`define CXD_CHAR_PIXELS      4'h8
`define CXD_HTOTAL_LAG       2'h2

`endif

/* cxd_pkg.sv */
// Types shared by the extended display controls: register layouts and decode enumerations.
// Assumes the constants header is present in the same folder.
package cxd_pkg;

   // Extended display control register layout, bit 7 first.
   typedef struct packed {
      logic       blank_ext_en;    // Blank end extension enable.
      logic       text_fast_page;  // Font fetch by fast-page cycles.
      logic       blank_from_de;   // DAC blanking from display enable.
      logic       row_offset_b8;   // Row offset bit 8.
      logic [1:0] start_b18_17;    // Start address bits 18:17.
      logic       ext_wrap;        // Extended address wrap.
      logic       start_b16;       // Start address bit 16.
   } cxd_ext_disp_type;

   // Sync adjust and lock register layout, bit 7 first.
   typedef struct packed {
      logic       vsync_lock;      // Vertical sync pin taken as input.
      logic       hsync_lock;      // Horizontal sync pin taken as input.
      logic [2:0] htotal_adj;      // Horizontal total adjust code.
      logic [2:0] hsync_delay;     // Extra pixel clocks of sync delay.
   } cxd_sync_adj_type;

   // Overlay extended control register layout, bit 7 first.
   typedef struct packed {
      logic       start_b19;       // Start address bit 19.
      logic       timing_internal; // Overlay timing from the internal window.
      logic       chroma_select;   // Compare video data against chroma range.
      logic       key_tag_en;      // Tag bit colour key.
      logic       key_width16;     // Full 16-bit compare.
      logic [1:0] dac_switch;      // DAC mode switch control.
      logic       reserved;        // Reads as zero.
   } cxd_ovl_ext_type;

   // Overlay switch selection decode.
   typedef enum logic [1:0] {
      SW_OFF,
      SW_TIMING,
      SW_TIMING_KEY,
      SW_KEY_ONLY
   } cxd_switch_type;

   // Horizontal total adjust sequencer states.
   typedef enum logic [1:0] {
      ADJ_IDLE,
      ADJ_WAIT,
      ADJ_STRETCH
   } cxd_adj_state_type;

endpackage : cxd_pkg

/* cxd_sync_src.sv */
// Genlock sync source model driving both external sync pins of the device.
// Assumes one request pulse per sync burst, on the pixel clock.
`timescale 1ns/100ps
module cxd_sync_src
(
   input  wire logic clk,
   input  wire logic go,
   output logic      hsync,
   output logic      vsync
);
   int cnt = 0; // Cycles left in the burst.
   initial {hsync, vsync} = 2'b00;
   // The external master supplies both syncs, held long enough to pass the input filter.
   always @(posedge clk)
   begin
      cnt <= go ? 6 : (cnt > 0 ? cnt - 1 : 0);
      {hsync, vsync} <= {2{go || cnt > 1}};
   end
endmodule : cxd_sync_src

/* cxd_ext_display_chk.sv */
// Checker of the extended display controls, watching the top module ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module cxd_ext_display_chk
(
   input wire logic        MCLK, SYS_RST, CRTC_BLANK, DISPLAY_EN, DAC_BLANK, BLANK_END_EXT_EN, PIXEL_PORT_OE,
   input wire logic        HSYNC_OE, VSYNC_OE, HSYNC_RESTART, VSYNC_RESTART, CHAR_CLK,
   input wire logic [7:0]  BLANK_OVERFLOW_MISC, ROW_OFFSET_LO,
   input wire logic [15:0] START_ADDR_LO,
   input wire logic [1:0]  VBLANK_END_HI, HBLANK_END_HI,
   input wire logic [8:0]  ROW_OFFSET,
   input wire logic [19:0] START_ADDR
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   a_blank_ext_gate: assert property (!BLANK_END_EXT_EN |-> VBLANK_END_HI == 2'h0 && HBLANK_END_HI == 2'h0)
      else $error("Blank end bits pass while disabled.");
   a_dac_blank_src: assert property (!$past(SYS_RST) |-> DAC_BLANK == $past(CRTC_BLANK) || DAC_BLANK == !$past(DISPLAY_EN))
      else $error("DAC blank from neither source.");
   a_row_offset_lo: assert property (!$past(SYS_RST) |-> ROW_OFFSET[7:0] == $past(ROW_OFFSET_LO))
      else $error("Row offset low byte wrong.");
   a_start_addr_lo: assert property (!$past(SYS_RST) |-> START_ADDR[15:0] == $past(START_ADDR_LO))
      else $error("Start address low bits wrong.");
   a_pixel_port_dir: assert property (!$past(SYS_RST) |-> PIXEL_PORT_OE == (($past(BLANK_OVERFLOW_MISC) & 8'h0C) == 8'h00))
      else $error("Pixel port direction wrong.");
   a_hsync_restart: assert property (HSYNC_RESTART |-> !HSYNC_OE ##1 !HSYNC_RESTART)
      else $error("Horizontal restart while driving.");
   a_vsync_restart: assert property (VSYNC_RESTART |-> !VSYNC_OE ##1 !VSYNC_RESTART)
      else $error("Vertical restart while driving.");
   a_char_clk_gap: assert property (CHAR_CLK |=> !CHAR_CLK [*4])
      else $error("Character shorter than five pixels.");
endmodule : cxd_ext_display_chk
bind cxd_ext_display cxd_ext_display_chk cxd_ext_display_chk_inst (.*);

/* crtc_extended_display_controls_tb.sv */
// Testbench of the extended display controls: registers, decode, genlock, character adjust.
// Assumes the design, its header, the checker and the genlock model in one folder.
`timescale 1ns/100ps
`include "cxd_defines.svh"
module crtc_extended_display_controls_tb;
`define CHK(n,e,g) begin checks_done++; if ((e) !== (g)) begin n_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
   logic MCLK = 0, SYS_RST = 1, IO_WR = 0, IO_RD = 0, IO_DATA_SEL = 0, DWORD_MODE = 0, CHAIN4_MODE = 0, CRTC_BLANK = 0;
   logic DISPLAY_EN = 0, OVERLAY_WIN_INT = 0, HSYNC_INT = 0, VSYNC_INT = 0, HTOTAL_MATCH = 0, FIELD_END = 0, FRAME_START = 0;
   logic EXT_VIDEO_WINDOW_IN_N = 1, CHROMA_IN_RANGE = 0, sync_go = 0;
   logic [7:0]  IO_WDATA = 0, BLANK_OVERFLOW_MISC = 0, ROW_OFFSET_LO = 0, COLOR_KEY_LOW = 0, COLOR_KEY_HIGH = 0, IO_RDATA, v, w;
   logic ov, tm, k, sw;
   logic [18:0] xa;
   logic [15:0] START_ADDR_LO = 0, GFX_PIXEL = 0;
   logic [16:0] HOST_ADDR = 0;
   logic [6:0]  HOST_OFFSET = 0;
   logic HSYNC_I, VSYNC_I, BLANK_END_EXT_EN, FONT_FAST_PAGE, DAC_BLANK, OVERLAY_WINDOW_OUT_N, HSYNC_O, HSYNC_OE, VSYNC_O;
   logic VSYNC_OE, HSYNC_RESTART, VSYNC_RESTART, FIELD_ODD, CHAR_CLK, OVERLAY_TIMING, COLOR_KEY_MATCH, OVERLAY_SWITCH;
   logic DAC_SWITCH, PIXEL_PORT_OE;
   logic [1:0]  VBLANK_END_HI, HBLANK_END_HI;
   logic [8:0]  ROW_OFFSET;
   logic [19:0] START_ADDR;
   logic [18:0] CRTC_MEM_ADDR, DRAM_HOST_ADDR;
   logic [7:0]  idx [6] = '{8'h1B, 8'h1C, 8'h1D, 8'h25, 8'h27, 8'h30}; // Places read after reset.
   logic [7:0]  rst [6] = '{8'h00, 8'h00, 8'h00, `CXD_PART_STATUS, {`CXD_DEVICE_ID, 2'b00}, 8'h00};
   int n_errors = 0, checks_done = 0, seed = 14, t, gap, odd;
   cxd_ext_display cxd_ext_display_inst (.*);
   cxd_sync_src cxd_sync_src_inst (.clk(MCLK), .go(sync_go), .hsync(HSYNC_I), .vsync(VSYNC_I));
   initial forever #2.5 MCLK = ~MCLK;
   // Index cycle then one data cycle; ends after outputs have settled.
   task automatic reg_op(input logic wr, input logic [7:0] i, input logic [7:0] d);
      @(negedge MCLK) {IO_WR, IO_DATA_SEL, IO_WDATA} = {2'b10, i};
      @(negedge MCLK) {IO_WR, IO_RD, IO_DATA_SEL, IO_WDATA} = {wr, !wr, 1'b1, d};
      @(negedge MCLK) {IO_WR, IO_RD} = 2'b00;
      @(negedge MCLK);
   endtask : reg_op
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      repeat (5) @(negedge MCLK);
      SYS_RST = 0;
      reg_op(1, 8'h27, 8'hFF);
      for (int i = 0; i < 6; i++) begin reg_op(0, idx[i], 0); `CHK("regs", rst[i], IO_RDATA) end
      reg_op(1, 8'h1D, 8'hFF);
      reg_op(0, 8'h1D, 0);
      `CHK("ovl", 8'hFE, IO_RDATA)
      $display("register test done");
      for (int i = 0; i < 8; i++)
      begin
         {v, w} = $random(seed);
         {BLANK_OVERFLOW_MISC, ROW_OFFSET_LO, START_ADDR_LO} = $random(seed);
         {CRTC_BLANK, DISPLAY_EN, OVERLAY_WIN_INT, EXT_VIDEO_WINDOW_IN_N, CHROMA_IN_RANGE, HSYNC_INT, VSYNC_INT} = $random(seed);
         {HOST_ADDR, HOST_OFFSET, CHAIN4_MODE, GFX_PIXEL} = {$random(seed), $random(seed)};
         {COLOR_KEY_HIGH, COLOR_KEY_LOW} = w[0] ? GFX_PIXEL : $random(seed);
         xa = {HOST_ADDR[16:12] + HOST_OFFSET, HOST_ADDR[11:0]};
         reg_op(1, 8'h1B, v);
         reg_op(1, 8'h1D, {v[1], w[6:1], 1'b0});
         ov = v[5] ? CRTC_BLANK : OVERLAY_WIN_INT;
         tm = w[6] ? ov : !EXT_VIDEO_WINDOW_IN_N;
         k  = w[5] ? CHROMA_IN_RANGE : !w[3] ? GFX_PIXEL[7:0] == COLOR_KEY_LOW
            : w[4] ? GFX_PIXEL[15] == COLOR_KEY_HIGH[7] : GFX_PIXEL == {COLOR_KEY_HIGH, COLOR_KEY_LOW};
         sw = BLANK_OVERFLOW_MISC[3] ? k & (BLANK_OVERFLOW_MISC[2] | tm) : BLANK_OVERFLOW_MISC[2] & tm;
         `CHK("overlay_window_out", !ov, OVERLAY_WINDOW_OUT_N)
         `CHK("otim", tm, OVERLAY_TIMING)
         `CHK("key", k, COLOR_KEY_MATCH)
         `CHK("osw", sw, OVERLAY_SWITCH)
         `CHK("dsw", !w[2] & (sw ^ w[1]), DAC_SWITCH)
         `CHK("dram", v[1] & CHAIN4_MODE ? {xa[18:2], xa[17:16]} : {3'h0, HOST_ADDR[15:0]}, DRAM_HOST_ADDR)
         `CHK("sync", {HSYNC_INT, VSYNC_INT}, {HSYNC_O, VSYNC_O})
         `CHK("ext", (v[7] | v[5]) ? BLANK_OVERFLOW_MISC[7:4] : 4'h0, {VBLANK_END_HI, HBLANK_END_HI})
         `CHK("fast", v[6], FONT_FAST_PAGE)
         `CHK("dac", v[5] ? !DISPLAY_EN : CRTC_BLANK, DAC_BLANK)
         `CHK("row", {v[4], ROW_OFFSET_LO}, ROW_OFFSET)
         `CHK("start", {v[1], v[3:2], v[0], START_ADDR_LO}, START_ADDR)
         `CHK("pport", BLANK_OVERFLOW_MISC[3:2] == 2'b00, PIXEL_PORT_OE)
      end
      $display("decode test done");
      BLANK_OVERFLOW_MISC = 8'h01;
      FIELD_END = 1;
      @(negedge MCLK) FIELD_END = 0;
      reg_op(1, 8'h1C, 8'h40);
      `CHK("oe", 2'b01, {HSYNC_OE, VSYNC_OE})
      reg_op(1, 8'h1C, 8'hC0);
      `CHK("voe", 1'b0, VSYNC_OE)
      sync_go = 1;
      @(negedge MCLK) sync_go = 0;
      t = 0;
      while (VSYNC_RESTART !== 1'b1 && t < 20) begin @(negedge MCLK); t++; end
      `CHK("vrst", 1'b1, VSYNC_RESTART)
      `CHK("hrst", 1'b1, HSYNC_RESTART)
      @(negedge MCLK) `CHK("field", 1'b0, FIELD_ODD)
      $display("genlock test done");
      for (int c = 0; c < 8; c++)
      begin
         reg_op(1, 8'h1C, {2'b11, c[2:0], 3'b000});
         @(posedge CHAR_CLK);
         @(negedge MCLK) HTOTAL_MATCH = 1;
         @(negedge MCLK) HTOTAL_MATCH = 0;
         {gap, odd} = {32'd1, 32'd8};
         repeat (60) @(negedge MCLK) begin gap++; if (CHAR_CLK) begin if (gap != 8) odd = gap; gap = 0; end end
         `CHK("adj", c == 0 ? 8 : (c < 4 ? 4 + c : 5 + c), odd)
      end
      $display("character adjust test done");
      tally_and_finish();
   end
   initial
   begin
      #20000;
      n_errors++;
      tally_and_finish();
   end
endmodule : crtc_extended_display_controls_tb
